//--- src/sct_pkg.sv
/*
  package for the sct status and log-access block: command codes, register
  values, page layout offsets and status codes.
  assumes nothing of its surroundings.
*/
package sct_pkg;
  // task file command codes
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] CMD_LOG_READ = 8'h2F;
  localparam logic [7:0] CMD_LOG_WRITE = 8'h3F;
  // smart sub-feature codes and signature
  localparam logic [7:0] FEAT_SMART_READ = 8'hD5;
  localparam logic [7:0] FEAT_SMART_WRITE = 8'hD6;
  localparam logic [7:0] SIG_LOW = 8'h4F;
  localparam logic [7:0] SIG_HIGH = 8'hC2;
  // log pages
  localparam logic [7:0] PAGE_STATUS = 8'hE0;
  localparam logic [7:0] PAGE_DATA = 8'hE1;
  localparam logic [7:0] LBA_MID_ZERO = 8'h00;
  localparam logic [7:0] ONE_SECTOR = 8'h01;
  // status page fields
  localparam logic [15:0] FORMAT_VERSION = 16'h0003;
  localparam logic [15:0] SPEC_LEVEL = 16'h0001;
  localparam logic [15:0] EXT_BUSY = 16'hFFFF;
  localparam logic [15:0] EXT_OK = 16'h0000;
  localparam logic [15:0] EXT_NO_CMD = 16'h000B;
  localparam logic [8:0] PAGE_BYTES = 9'h1FF; // last byte index of a sector
  localparam logic [8:0] OFS_FMT = 9'h000;
  localparam logic [8:0] OFS_VER = 9'h002;
  localparam logic [8:0] OFS_SPEC = 9'h004;
  localparam logic [8:0] OFS_FLAGS = 9'h006;
  localparam logic [8:0] OFS_STATE = 9'h00A;
  localparam logic [8:0] OFS_EXT = 9'h00E;
  localparam int FLAG_SEG_INIT = 0;
  // drive activity codes reported in byte 10
  typedef enum logic [7:0] {
    SCT_ACT_IDLE = 8'h00,
    SCT_ACT_STANDBY = 8'h01,
    SCT_ACT_SLEEP = 8'h02,
    SCT_ACT_SELFTEST = 8'h03,
    SCT_ACT_OFFLINE = 8'h04,
    SCT_ACT_SCT = 8'h05
  } sct_activity_t;
  // ata status answer
  localparam logic [7:0] ATA_OK = 8'h50;
  localparam logic [7:0] ATA_ERR = 8'h51;
endpackage : sct_pkg

//--- src/sct_link_if.sv
/*
  interface joining host controller and drive command logic.
  assumes both ends run on the drive clock clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface sct_link_if;
  logic cmd_valid;       // one-cycle task file strobe
  logic [7:0] feature;
  logic [7:0] sec_count;
  logic [7:0] lba_low;
  logic [7:0] lba_mid;
  logic [7:0] lba_high;
  logic [7:0] command;
  logic resp_valid;      // one-cycle ata status strobe
  logic [7:0] ata_status;
  logic [15:0] ext_status;
  logic rd_valid;        // read data byte strobe
  logic [7:0] rd_data;
  logic rd_last;
  modport drive (input cmd_valid, feature, sec_count, lba_low, lba_mid, lba_high, command,
    output resp_valid, ata_status, ext_status, rd_valid, rd_data, rd_last);
  modport host (output cmd_valid, feature, sec_count, lba_low, lba_mid, lba_high, command,
    input resp_valid, ata_status, ext_status, rd_valid, rd_data, rd_last);
endinterface : sct_link_if
`default_nettype wire

//--- src/sct_page_rom.sv
/*
  combinational byte source for the 512-byte status page.
  assumes the caller registers the byte before it leaves the drive.
*/
`timescale 1ns/10ps
`default_nettype none
module sct_page_rom (
  input wire logic [8:0] idx,
  input wire logic [15:0] impl_version,
  input wire logic seg_init,
  input wire logic [7:0] activity,
  input wire logic [15:0] ext_status,
  output logic [7:0] data
);
  always_comb begin
    data = 8'h00;
    unique case (idx)
      sct_pkg::OFS_FMT: data = sct_pkg::FORMAT_VERSION[7:0];
      sct_pkg::OFS_FMT + 9'h001: data = sct_pkg::FORMAT_VERSION[15:8];
      sct_pkg::OFS_VER: data = impl_version[7:0];
      sct_pkg::OFS_VER + 9'h001: data = impl_version[15:8];
      sct_pkg::OFS_SPEC: data = sct_pkg::SPEC_LEVEL[7:0];
      sct_pkg::OFS_SPEC + 9'h001: data = sct_pkg::SPEC_LEVEL[15:8];
      sct_pkg::OFS_FLAGS: data = {7'h00, seg_init};
      sct_pkg::OFS_STATE: data = activity;
      sct_pkg::OFS_EXT: data = ext_status[7:0];
      sct_pkg::OFS_EXT + 9'h001: data = ext_status[15:8];
      default: data = 8'h00;
    endcase
  end
endmodule : sct_page_rom
`default_nettype wire

//--- src/sct_drive.sv
/*
  drive end: decodes smart and log commands for sct status and data
  transfer, streams the status page, keeps the segment-initialized flag.
  assumes one clock clk_sys shared with the host end; the flag's
  nonvolatile copy lives outside and is restored through nv_* ports.
  assumes the host waits for done before its next command; a command
  that lands while a page streams is dropped without an answer.
  the activity code on power_state is shown as it stands in byte 10.
*/
// Notes on behaviour
// - log data transfer uses E1h, 2Fh/3Fh
// - ata status means accepted, not done
// - host polls status for long actions
// - status page served as log E0h
// - status request accepted whenever commands allowed
// - status read leaves power, background alone
// - smart status request register values
// - log ext status request register values
// - bytes 1:0 format version 0003h
// - bytes 3:2 vendor implementation version
// - bytes 5:4 spec level 0001h
// - flag bit0 set after full write-same
// - any user write clears flag
// - capacity change clears flag
// - flag kept across power cycles
// - byte 10 reports drive activity
// - extended status FFFFh while busy
// - data transfer before sct command: 000Bh
`timescale 1ns/10ps
`default_nettype none
module sct_drive #(
  parameter logic [15:0] IMPL_VERSION = 16'h0100 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  sct_link_if.drive link,
  input wire logic user_write,
  input wire logic capacity_change,
  input wire logic write_same_done,
  input wire logic sct_cmd_issued,
  input wire logic sct_busy,
  input wire logic [7:0] power_state,
  input wire logic nv_load,
  input wire logic nv_seg_init,
  output logic seg_init,
  output logic data_xfer,
  output logic data_write
);
  typedef enum logic [1:0] {
    SCT_ST_IDLE = 2'b01,
    SCT_ST_SEND = 2'b10
  } sct_state_t;

  sct_state_t state_reg;
  logic [8:0] idx_reg;
  logic seg_init_reg;
  logic sct_seen_reg;
  logic [15:0] ext_reg;
  logic [7:0] page_byte;
  logic [15:0] ext_live;
  logic is_status;
  logic is_xfer;
  logic xfer_wr;
  logic drive_idle;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  always_comb begin
    is_status = (link.command == sct_pkg::CMD_SMART && link.feature == sct_pkg::FEAT_SMART_READ
      && link.sec_count == sct_pkg::ONE_SECTOR && link.lba_low == sct_pkg::PAGE_STATUS
      && link.lba_mid == sct_pkg::SIG_LOW && link.lba_high == sct_pkg::SIG_HIGH);
    if (link.command == sct_pkg::CMD_LOG_READ && link.lba_low == sct_pkg::PAGE_STATUS
        && link.lba_mid == sct_pkg::LBA_MID_ZERO) begin
      is_status = 1'b1;
    end
    is_xfer = (link.command == sct_pkg::CMD_LOG_READ || link.command == sct_pkg::CMD_LOG_WRITE)
      && link.lba_low == sct_pkg::PAGE_DATA && link.lba_mid == sct_pkg::LBA_MID_ZERO;
    xfer_wr = link.command == sct_pkg::CMD_LOG_WRITE;
    if (link.command == sct_pkg::CMD_SMART && link.lba_low == sct_pkg::PAGE_DATA
        && link.lba_mid == sct_pkg::SIG_LOW && link.lba_high == sct_pkg::SIG_HIGH
        && (link.feature == sct_pkg::FEAT_SMART_READ || link.feature == sct_pkg::FEAT_SMART_WRITE)) begin
      is_xfer = 1'b1;
      xfer_wr = link.feature == sct_pkg::FEAT_SMART_WRITE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // extended status: busy overrides last result
  // busy reads FFFFh
  assign ext_live = sct_busy ? sct_pkg::EXT_BUSY : ext_reg;

  // commands are only taken between pages, so a stray strobe cannot log a code
  assign drive_idle = state_reg == SCT_ST_IDLE;

  sct_page_rom sct_page_rom_i (
    .idx(idx_reg),
    .impl_version(IMPL_VERSION),
    .seg_init(seg_init_reg),
    .activity(power_state),
    .ext_status(ext_live),
    .data(page_byte)
  );

  // remembers whether any sct command has been issued
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sct_seen_reg <= 1'b0;
    end else if (sct_cmd_issued) begin
      sct_seen_reg <= 1'b1;
    end
  end

  // last extended status code
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_reg <= sct_pkg::EXT_OK;
    end else if (sct_cmd_issued) begin
      ext_reg <= sct_pkg::EXT_OK;
    end else if (link.cmd_valid && drive_idle && is_xfer && !sct_seen_reg) begin
      ext_reg <= sct_pkg::EXT_NO_CMD;
    end
  end

  // segment-initialized flag; clears outrank a finishing write-same
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_init_reg <= 1'b0;
    end else if (nv_load) begin
      seg_init_reg <= nv_seg_init;
    end else if (user_write || capacity_change) begin
      seg_init_reg <= 1'b0;
    end else if (write_same_done) begin
      seg_init_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer and page streaming; nothing here touches power or background
  // status accepted in any idle cycle
  // no power or background side effect
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SCT_ST_IDLE;
      idx_reg <= 9'h000;
      link.resp_valid <= 1'b0;
      link.ata_status <= sct_pkg::ATA_OK;
      link.ext_status <= sct_pkg::EXT_OK;
      link.rd_valid <= 1'b0;
      link.rd_data <= 8'h00;
      link.rd_last <= 1'b0;
      data_xfer <= 1'b0;
      data_write <= 1'b0;
    end else begin
      link.resp_valid <= 1'b0;
      link.rd_valid <= 1'b0;
      link.rd_last <= 1'b0;
      data_xfer <= 1'b0;
      data_write <= 1'b0;
      unique case (state_reg)
        SCT_ST_IDLE: begin
          if (link.cmd_valid) begin
            link.resp_valid <= 1'b1;
            link.ext_status <= ext_live;
            if (is_status) begin
              link.ata_status <= sct_pkg::ATA_OK;
              idx_reg <= 9'h000;
              state_reg <= SCT_ST_SEND;
            end else if (is_xfer && sct_seen_reg) begin
              link.ata_status <= sct_pkg::ATA_OK;
              data_xfer <= 1'b1;
              data_write <= xfer_wr;
            end else begin
              link.ata_status <= sct_pkg::ATA_ERR;
              if (is_xfer) begin
                link.ext_status <= sct_pkg::EXT_NO_CMD;
              end
            end
          end
        end
        SCT_ST_SEND: begin
          link.rd_valid <= 1'b1;
          link.rd_data <= page_byte;
          link.rd_last <= idx_reg == sct_pkg::PAGE_BYTES;
          idx_reg <= idx_reg + 9'h001;
          if (idx_reg == sct_pkg::PAGE_BYTES) begin
            state_reg <= SCT_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign seg_init = seg_init_reg;
endmodule : sct_drive
`default_nettype wire

//--- src/sct_host.sv
/*
  host end: turns user requests into task file loads for sct status and
  data transfer, and passes back answers and page bytes.
  assumes one clock clk_sys shared with the drive end.
*/
`timescale 1ns/10ps
`default_nettype none
module sct_host (
  input wire logic clk_sys,
  input wire logic resetn,
  sct_link_if.host link,
  input wire logic req_status,
  input wire logic req_use_smart,
  input wire logic req_xfer,
  input wire logic req_write,
  input wire logic [7:0] req_count,
  output logic busy,
  output logic done,
  output logic [7:0] done_status,
  output logic [15:0] done_ext,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic wait_page_reg;

  ////////////////////////////////////////////////////////////////////////
  // issue task file and track the answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      link.cmd_valid <= 1'b0;
      link.feature <= 8'h00;
      link.sec_count <= 8'h00;
      link.lba_low <= 8'h00;
      link.lba_mid <= 8'h00;
      link.lba_high <= 8'h00;
      link.command <= 8'h00;
      busy <= 1'b0;
      wait_page_reg <= 1'b0;
      done <= 1'b0;
      done_status <= 8'h00;
      done_ext <= 16'h0000;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      link.cmd_valid <= 1'b0;
      done <= 1'b0;
      byte_valid <= link.rd_valid;
      byte_data <= link.rd_data;
      if (!busy && req_status) begin
        link.cmd_valid <= 1'b1;
        busy <= 1'b1;
        wait_page_reg <= 1'b1;
        link.sec_count <= sct_pkg::ONE_SECTOR;
        link.lba_low <= sct_pkg::PAGE_STATUS;
        if (req_use_smart) begin
          link.feature <= sct_pkg::FEAT_SMART_READ;
          link.lba_mid <= sct_pkg::SIG_LOW;
          link.lba_high <= sct_pkg::SIG_HIGH;
          link.command <= sct_pkg::CMD_SMART;
        end else begin
          link.feature <= 8'h00;
          link.lba_mid <= sct_pkg::LBA_MID_ZERO;
          link.lba_high <= 8'h00;
          link.command <= sct_pkg::CMD_LOG_READ;
        end
      end else if (!busy && req_xfer) begin
        link.cmd_valid <= 1'b1;
        busy <= 1'b1;
        wait_page_reg <= 1'b0;
        link.feature <= 8'h00;
        link.sec_count <= req_count;
        link.lba_low <= sct_pkg::PAGE_DATA;
        link.lba_mid <= sct_pkg::LBA_MID_ZERO;
        link.lba_high <= 8'h00;
        link.command <= req_write ? sct_pkg::CMD_LOG_WRITE : sct_pkg::CMD_LOG_READ;
      end
      if (link.resp_valid) begin
        done_status <= link.ata_status;
        done_ext <= link.ext_status;
        if (!wait_page_reg || link.ata_status != sct_pkg::ATA_OK) begin
          done <= 1'b1;
          busy <= 1'b0;
        end
      end
      if (link.rd_valid && link.rd_last) begin
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : sct_host
`default_nettype wire

//--- testbench/sct_link_properties.sv
/*
  concurrent checks on the link between host and drive ends.
  assumes plain link signals on clk_sys, instantiated by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module sct_link_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] feature,
  input wire logic [7:0] sec_count,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_high,
  input wire logic [7:0] command,
  input wire logic resp_valid,
  input wire logic [7:0] ata_status,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_last
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [9:0] idx_reg;
  //////////////////////////////////////////////////////////////////////////
  // page byte index, restarted by every answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx_reg <= 10'h000;
    end else if (resp_valid) begin
      idx_reg <= 10'h000;
    end else if (rd_valid) begin
      idx_reg <= idx_reg + 10'h001;
    end
  end
  sequence log_status_req;
    cmd_valid && command == sct_pkg::CMD_LOG_READ && lba_low == sct_pkg::PAGE_STATUS && lba_mid == 8'h00;
  endsequence
  sequence smart_status_req;
    cmd_valid && command == sct_pkg::CMD_SMART && feature == sct_pkg::FEAT_SMART_READ && sec_count == 8'h01
      && lba_low == sct_pkg::PAGE_STATUS && lba_mid == sct_pkg::SIG_LOW && lba_high == sct_pkg::SIG_HIGH;
  endsequence
  sequence page_start;
    resp_valid && ata_status == sct_pkg::ATA_OK ##1 rd_valid [*8];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_cmd_answered: assert property (cmd_valid |=> resp_valid)
    else $error("command not answered next cycle");
  chk_answer_caused: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  chk_log_status: assert property (log_status_req |=> page_start)
    else $error("log status request not served");
  chk_smart_status: assert property (smart_status_req |=> page_start)
    else $error("smart status request not served");
  chk_format_word: assert property (rd_valid && idx_reg < 10'h002 |->
    rd_data == (idx_reg == 10'h000 ? 8'h03 : 8'h00)) else $error("format word wrong");
  chk_spec_word: assert property (rd_valid && idx_reg inside {10'h004, 10'h005} |->
    rd_data == (idx_reg == 10'h004 ? 8'h01 : 8'h00)) else $error("spec level word wrong");
  chk_flag_reserved: assert property (rd_valid && idx_reg inside {[10'h006:10'h009]} |->
    (rd_data & (idx_reg == 10'h006 ? 8'hFE : 8'hFF)) == 8'h00) else $error("flag bits wrong");
  chk_reserved_zero: assert property (rd_valid && (idx_reg inside {[10'h00B:10'h00D]} || idx_reg > 10'h00F)
    |-> rd_data == 8'h00) else $error("reserved byte not zero");
  chk_last_byte: assert property (rd_last |-> rd_valid && idx_reg == 10'h1FF)
    else $error("last byte mark misplaced");
endmodule : sct_link_properties
`default_nettype wire

//--- testbench/sct_status_log_access_test.sv
/*
  self-checking bench joining host and drive ends over the link.
  assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module sct_status_log_access_test;
  localparam logic [15:0] IMPL = 16'h2A5C; // arbitrary value
  logic clk_sys, resetn, user_write, capacity_change, write_same_done, sct_cmd_issued, sct_busy;
  logic nv_load, nv_seg_init, seg_init, data_xfer, data_write, req_status, req_use_smart, req_xfer;
  logic req_write, busy, done, byte_valid, xfer_seen, write_seen;
  logic [7:0] power_state, req_count, done_status, byte_data, got_status;
  logic [15:0] done_ext, got_ext, last_ext;
  logic [7:0] pg [0:511];
  int fails, num_checks, nb;
  sct_link_if sct_link_if_i ();
  sct_drive #(.IMPL_VERSION(IMPL)) sct_drive_i (.clk_sys(clk_sys), .resetn(resetn), .link(sct_link_if_i),
    .user_write(user_write), .capacity_change(capacity_change), .write_same_done(write_same_done),
    .sct_cmd_issued(sct_cmd_issued), .sct_busy(sct_busy), .power_state(power_state), .nv_load(nv_load),
    .nv_seg_init(nv_seg_init), .seg_init(seg_init), .data_xfer(data_xfer), .data_write(data_write));
  sct_host sct_host_i (.clk_sys(clk_sys), .resetn(resetn), .link(sct_link_if_i), .req_status(req_status),
    .req_use_smart(req_use_smart), .req_xfer(req_xfer), .req_write(req_write), .req_count(req_count),
    .busy(busy), .done(done), .done_status(done_status), .done_ext(done_ext), .byte_valid(byte_valid),
    .byte_data(byte_data));
  sct_link_properties sct_link_properties_i (.clk_sys(clk_sys), .resetn(resetn),
    .cmd_valid(sct_link_if_i.cmd_valid), .feature(sct_link_if_i.feature), .sec_count(sct_link_if_i.sec_count),
    .lba_low(sct_link_if_i.lba_low), .lba_mid(sct_link_if_i.lba_mid), .lba_high(sct_link_if_i.lba_high),
    .command(sct_link_if_i.command), .resp_valid(sct_link_if_i.resp_valid),
    .ata_status(sct_link_if_i.ata_status), .rd_valid(sct_link_if_i.rd_valid),
    .rd_data(sct_link_if_i.rd_data), .rd_last(sct_link_if_i.rd_last));
  //////////////////////////////////////////////////////////////////////////
  // clock and capture of page bytes and transfer pulses
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (byte_valid && nb < 512) pg[nb] = byte_data;
    if (byte_valid) nb = nb + 1;
    if (data_xfer) xfer_seen = 1'b1;
    if (data_write) write_seen = 1'b1;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] exp_byte(input int i, input logic [7:0] act, input logic flag,
    input logic [15:0] ext);
    exp_byte = 8'h00;
    case (i)
      0: exp_byte = sct_pkg::FORMAT_VERSION[7:0];
      1: exp_byte = sct_pkg::FORMAT_VERSION[15:8];
      2: exp_byte = IMPL[7:0];
      3: exp_byte = IMPL[15:8];
      4: exp_byte = sct_pkg::SPEC_LEVEL[7:0];
      5: exp_byte = sct_pkg::SPEC_LEVEL[15:8];
      6: exp_byte = {7'h00, flag};
      10: exp_byte = act;
      14: exp_byte = ext[7:0];
      15: exp_byte = ext[15:8];
      default: exp_byte = 8'h00;
    endcase
  endfunction : exp_byte
  // one host request, waits for done under a bound
  task automatic run(input logic st, input logic smart, input logic wr);
    int n = 0;
    nb = 0;
    xfer_seen = 1'b0;
    write_seen = 1'b0;
    req_status = st;
    req_use_smart = smart;
    req_xfer = !st;
    req_write = wr;
    @(negedge clk_sys);
    req_status = 1'b0;
    req_xfer = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 2000) begin
      fails++;
      test_done;
    end
    check("host idle", {15'h0000, busy}, 16'h0000);
    got_status = done_status;
    got_ext = done_ext;
    @(negedge clk_sys);
  endtask : run
  task automatic page_ok(input logic flag);
    logic [15:0] ext;
    ext = sct_busy ? sct_pkg::EXT_BUSY : last_ext;
    check("page status", {8'h00, got_status}, {8'h00, sct_pkg::ATA_OK});
    check("page length", 16'(nb), 16'h0200);
    for (int i = 0; i < 512; i++) begin
      check("page byte", {8'h00, pg[i]}, {8'h00, exp_byte(i, power_state, flag, ext)});
    end
  endtask : page_ok
  // strobes {sct_cmd_issued, nv_load, capacity_change, user_write, write_same_done}
  task automatic strobe(input logic [4:0] m);
    {sct_cmd_issued, nv_load, capacity_change, user_write, write_same_done} = m;
    @(negedge clk_sys);
    {sct_cmd_issued, nv_load, capacity_change, user_write, write_same_done} = 5'h00;
    @(negedge clk_sys);
  endtask : strobe
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done;
  end
  initial begin
    resetn = 1'b0;
    {sct_cmd_issued, nv_load, capacity_change, user_write, write_same_done} = 5'h00;
    {req_status, req_use_smart, req_xfer, req_write, sct_busy, nv_seg_init} = 6'h00;
    power_state = 8'h00;
    req_count = 8'h01;
    last_ext = sct_pkg::EXT_OK;
    void'($urandom(32'h3324));
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    run(1'b0, 1'b0, 1'b0);
    check("early xfer status", {8'h00, got_status}, {8'h00, sct_pkg::ATA_ERR});
    check("early xfer ext", got_ext, sct_pkg::EXT_NO_CMD);
    last_ext = sct_pkg::EXT_NO_CMD;
    $display("test early transfer done");
    // every activity code, request form picked at random, background busy for code 5, random for the rest
    for (int a = 0; a < 6; a++) begin
      power_state = 8'(a);
      sct_busy = (a == 5) ? 1'b1 : 1'($urandom);
      run(1'b1, 1'($urandom), 1'b0);
      page_ok(1'b0);
      check("flag kept", {15'h0000, seg_init}, 16'h0000);
    end
    $display("test status pages done");
    strobe(5'h01);
    check("flag set", {15'h0000, seg_init}, 16'h0001);
    run(1'b1, 1'b0, 1'b0);
    page_ok(1'b1);
    strobe(5'h02);
    check("flag write clear", {15'h0000, seg_init}, 16'h0000);
    strobe(5'h01);
    strobe(5'h04);
    check("flag resize clear", {15'h0000, seg_init}, 16'h0000);
    nv_seg_init = 1'b1;
    strobe(5'h08);
    check("flag restored", {15'h0000, seg_init}, 16'h0001);
    strobe(5'h03);
    check("flag clear wins", {15'h0000, seg_init}, 16'h0000);
    $display("test flag done");
    strobe(5'h10);
    sct_busy = 1'b0;
    for (int w = 0; w < 2; w++) begin
      req_count = ($urandom % 2) ? 8'h08 : 8'h01;
      run(1'b0, 1'b0, 1'(w));
      check("xfer status", {8'h00, got_status}, {8'h00, sct_pkg::ATA_OK});
      check("xfer pulses", {14'h0000, xfer_seen, write_seen}, {14'h0000, 1'b1, 1'(w)});
    end
    last_ext = sct_pkg::EXT_OK;
    // host polls while the action runs, then once it ends
    sct_busy = 1'b1;
    run(1'b1, 1'b1, 1'b0);
    page_ok(1'b0);
    sct_busy = 1'b0;
    run(1'b1, 1'b0, 1'b0);
    page_ok(1'b0);
    $display("test transfer and poll done");
    test_done;
  end
endmodule : sct_status_log_access_test
`default_nettype wire
